// *** pkg/drcd_pkg.sv ***
package drcd_pkg;

  // ==========================================================================
  // widths and timing
  localparam int          DATA_W       = 16;
  localparam int          ADDR_W       = 16;
  localparam int          DIV_W        = 2;
  localparam logic [1:0]  DIV_LAST     = 2'h3;     // divide by four
  localparam logic [1:0]  DIV_RESET    = 2'h0;
  localparam int          CNT_W        = 3;
  localparam logic [2:0]  INIT_MIN_CYC = 3'h5;     // system cycles to qualify
  localparam logic [2:0]  PC_CLR_CYC   = 3'h1;     // one full cycle after edge
  localparam logic [2:0]  CNT_RESET    = 3'h0;

  // ==========================================================================
  // register map (word aligned byte addresses)
  localparam logic [3:0]  REG_CTRL     = 4'h0;
  localparam logic [3:0]  REG_STATUS   = 4'h4;
  localparam logic [3:0]  REG_PC       = 4'h8;
  localparam int          CTRL_INT_EN  = 0;
  localparam int          CTRL_OVF     = 1;
  localparam int          STS_IRQ      = 0;
  localparam int          STS_INIT     = 1;
  localparam int          STS_QUAL     = 2;
  localparam int          STS_IRQ_LVL  = 3;
  localparam logic [15:0] ADDR_RESET   = 16'h0000;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic io_input_strobe_n;
    logic io_write_strobe_n;
    logic table_write_strobe_n;
    logic program_fetch_strobe_n;
  } drcd_strobes_t;

  typedef struct packed {
    logic              cyc;
    logic              stb;
    logic              we;
    logic [3:0]        sel;
    logic [3:0]        adr;
    logic [31:0]       dat;
  } drcd_wb_req_t;

  typedef enum logic [1:0] {
    DRCD_RUN   = 2'b00,
    DRCD_INIT  = 2'b01,
    DRCD_QUAL  = 2'b10
  } drcd_state_t;

endpackage

// *** test/drcd_bus_model.sv ***
`timescale 1ns/1ns
// ============================================================================
// far-side memory and peripherals on the data bus
module drcd_bus_model
  import drcd_pkg::*;
(
  input  wire logic                    clk_i,     // undivided input clock
  input  wire drcd_pkg::drcd_strobes_t strobes_i, // strobes from device
  input  wire logic [DATA_W-1:0]       data_o_i,  // device drive value
  input  wire logic                    data_oe_i, // device drive enable
  output logic [DATA_W-1:0]            data_i_o   // resolved bus level
);
  logic [DATA_W-1:0] last_ff = 16'h0000;
  // undriven bus shows 16'h5a3c while the io input strobe is low, otherwise the inverse of the last driven word, never a held value
  always @(posedge clk_i) begin
    if (data_oe_i) begin
      last_ff <= data_o_i;
    end
  end
  assign data_i_o = data_oe_i ? data_o_i : (!strobes_i.io_input_strobe_n ? 16'h5a3c : ~last_ff);
endmodule // drcd_bus_model

// *** test/tb.sv ***
`timescale 1ns/1ns
module tb;
  import drcd_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, init_n = 1'b1, int_n = 1'b1, grant = 1'b0, pc_we = 1'b0, oe = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] sel = 4'h0, adr = 4'h0;
  logic [31:0] dat = 32'h0, q;
  logic [15:0] pc = 16'h0, wd = 16'h0;
  drcd_strobes_t cs = 4'hf, so;
  logic [15:0] din, dout, rd, addr;
  logic [31:0] wdo;
  logic doe, sck, ce, ia, ip, ovf, ack;
  int num_errors = 0, n_tests = 0, cyc_n = 0, k, nce, nhi;
  typedef struct packed {logic w; logic [3:0] a; logic [31:0] d; logic [31:0] e;} drcd_row_t;
  drcd_row_t rows [9] = '{'{0,4'h0,0,0}, '{0,4'h4,0,0}, '{0,4'h8,0,0}, '{1,4'h0,3,0}, '{0,4'h0,0,3},
                         '{1,4'hc,32'hff,0}, '{0,4'hc,0,0}, '{1,4'h8,32'hffff,0}, '{0,4'h8,0,0}};
  always #4 clk_i = ~clk_i;
  dsp_reset_and_clock_divider dsp_reset_and_clock_divider_i (.clk_i(clk_i), .rst_i(rst_i),
    .init_request_n_i(init_n), .int_n_i(int_n), .int_grant_i(grant), .core_strobes_i(cs),
    .core_pc_we_i(pc_we), .core_pc_i(pc), .core_wr_data_i(wd), .core_wr_oe_i(oe), .data_i(din),
    .data_o(dout), .data_oe_o(doe), .core_rd_data_o(rd), .addr_o(addr), .strobes_o(so),
    .system_clock_output_o(sck), .sys_ce_o(ce), .init_active_o(ia), .int_pending_o(ip),
    .ovf_mode_o(ovf), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr),
    .wb_dat_i(dat), .wb_dat_o(wdo), .wb_ack_o(ack));
  drcd_bus_model drcd_bus_model_i (.clk_i(clk_i), .strobes_i(so), .data_o_i(dout), .data_oe_i(doe),
    .data_i_o(din));
  // ==========================================================================
  // helpers
  task automatic summarize();
    if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = wdo;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 3000) begin
      num_errors++;
      summarize();
    end
  end
  // ==========================================================================
  // sequence
  initial begin
    tick(5);
    rst_i <= 1'b0;
    for (k = 0; k < 9; k++) begin
      wb(rows[k].w, rows[k].a, rows[k].d);
      if (!rows[k].w) chk(q, rows[k].e);
    end
    tick(3);
    nce = 0; nhi = 0;
    repeat (16) begin
      @(posedge clk_i);
      if (ce === 1'b1) nce++;
      if (sck === 1'b1) nhi++;
    end
    chk(nce, 4);
    chk(nhi, 8);
    int_n <= 1'b0;
    tick(4);
    int_n <= 1'b1;
    tick(4);
    chk(ip, 1);
    grant <= 1'b1;
    tick(1);
    grant <= 1'b0;
    tick(3);
    chk(ip, 0);
    pc <= 16'h1234; pc_we <= 1'b1; cs <= 4'hb; oe <= 1'b1; wd <= 16'hbeef;
    tick(2);
    pc_we <= 1'b0;
    tick(2);
    chk(addr, 32'h1234);
    chk(doe, 1);
    chk(dout, 16'hbeef);
    chk(rd, 16'hbeef);
    int_n <= 1'b0;
    tick(4);
    int_n <= 1'b1;
    init_n <= 1'b0;
    tick(12);
    pc_we <= 1'b1;
    tick(28);
    chk(so, 4'hf);
    chk(doe, 0);
    chk(addr, 0);
    wb(1'b0, 4'h0, 0);
    chk(q, 32'h2);
    chk(ovf, 1);
    wb(1'b0, 4'h4, 0);
    chk(q, 32'h6);
    chk(ia, 1);
    pc_we <= 1'b0;
    init_n <= 1'b1;
    tick(6);
    chk(so, 4'hb);
    chk(doe, 1);
    chk(ip, 0);
    chk(addr, 0);
    cs <= 4'h7;
    oe <= 1'b0;
    tick(5);
    chk(rd, 16'h5a3c);
    rst_i <= 1'b1;
    tick(5);
    rst_i <= 1'b0;
    chk(so, 4'hf);
    chk(ovf, 0);
    chk(addr, 0);
    chk(doe, 0);
    chk(sck, 1);
    tick(3);
    chk(so, 4'h7);
    chk(ia, 0);
    summarize();
  end
endmodule // tb

// *** verilog/drcd_sync2.sv ***
`timescale 1ns/1ns
// ============================================================================
// two flip-flop synchroniser
module drcd_sync2 #(
  parameter int          W     = 1,
  parameter logic [15:0] RVAL  = 16'hffff
) (
  input  wire logic         clk_i,  // undivided input clock
  input  wire logic         rst_i,  // synchronous reset
  input  wire logic [W-1:0] d_i,    // asynchronous input
  output logic      [W-1:0] q_o     // synchronised output
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= RVAL[W-1:0];
      sync_ff <= RVAL[W-1:0];
    end else begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end

  assign q_o = sync_ff;
endmodule // drcd_sync2

// *** verilog/dsp_reset_and_clock_divider.sv ***
`timescale 1ns/1ns
module dsp_reset_and_clock_divider
  import drcd_pkg::*;
(
  input  wire logic                   clk_i,                 // crystal or external clock
  input  wire logic                   rst_i,                 // synchronous reset
  input  wire logic                   init_request_n_i,      // initialization pin
  input  wire logic                   int_n_i,               // external interrupt pin
  input  wire logic                   int_grant_i,           // core grants interrupt
  input  wire drcd_pkg::drcd_strobes_t core_strobes_i,       // strobes from core
  input  wire logic                   core_pc_we_i,          // core loads pc
  input  wire logic [ADDR_W-1:0]      core_pc_i,             // next pc from core
  input  wire logic [DATA_W-1:0]      core_wr_data_i,        // core write data
  input  wire logic                   core_wr_oe_i,          // core drives data bus
  input  wire logic [DATA_W-1:0]      data_i,                // data bus pin in
  output logic [DATA_W-1:0]           data_o,                // data bus pin out
  output logic                        data_oe_o,             // data bus enable
  output logic [DATA_W-1:0]           core_rd_data_o,        // synchronised bus data
  output logic [ADDR_W-1:0]           addr_o,                // address bus
  output drcd_pkg::drcd_strobes_t     strobes_o,             // bus strobes, low active
  output logic                        system_clock_output_o, // divided clock
  output logic                        sys_ce_o,              // one pulse per system cycle
  output logic                        init_active_o,         // core held in reset
  output logic                        int_pending_o,         // enabled interrupt request
  output logic                        ovf_mode_o,            // overflow mode to core
  input  wire logic                   wb_cyc_i,              // wishbone cycle
  input  wire logic                   wb_stb_i,              // wishbone strobe
  input  wire logic                   wb_we_i,               // wishbone write
  input  wire logic [3:0]             wb_sel_i,              // wishbone byte select
  input  wire logic [3:0]             wb_adr_i,              // wishbone byte address
  input  wire logic [31:0]            wb_dat_i,              // wishbone write data
  output logic [31:0]                 wb_dat_o,              // wishbone read data
  output logic                        wb_ack_o               // wishbone ack
);
  import drcd_pkg::*;

  // ==========================================================================
  // synchronisers
  logic                init_sync_n;
  logic                int_sync_n;
  logic [DATA_W-1:0]   data_sync;

  drcd_sync2 #(.W(2), .RVAL(16'hffff)) u_pin_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({init_request_n_i, int_n_i}),
    .q_o   ({init_sync_n, int_sync_n})
  );

  drcd_sync2 #(.W(DATA_W), .RVAL(16'h0000)) u_data_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (data_i),
    .q_o   (data_sync)
  );

  // ==========================================================================
  // clock divider
  logic [DIV_W-1:0] div_ff;
  logic             sysclk_ff;
  wire              sys_ce  = (div_ff == DIV_LAST);
  wire  [DIV_W-1:0] nxt_div = div_ff + 2'h1;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_ff    <= DIV_RESET;
      sysclk_ff <= 1'b1;
    end else begin
      div_ff    <= nxt_div;
      sysclk_ff <= ~nxt_div[DIV_W-1];
    end
  end

  // ==========================================================================
  // initialization sequencer
  drcd_state_t    state_ff;
  drcd_state_t    nxt_state;
  logic [CNT_W-1:0] cnt_ff;
  logic           int_prev_ff;
  wire            init_active = ~init_sync_n;
  wire            cnt_sat     = (cnt_ff == INIT_MIN_CYC);
  wire            pc_clear    = init_active & sys_ce & (cnt_ff == PC_CLR_CYC);
  wire [CNT_W-1:0] nxt_cnt    = !init_active ? CNT_RESET :
                                (sys_ce && !cnt_sat) ? cnt_ff + 3'h1 : cnt_ff;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      DRCD_RUN:  if (init_active) nxt_state = DRCD_INIT;
      DRCD_INIT: begin
        if (!init_active) nxt_state = DRCD_RUN;
        else if (cnt_sat) nxt_state = DRCD_QUAL;
      end
      DRCD_QUAL: if (!init_active) nxt_state = DRCD_RUN;
      default:   nxt_state = DRCD_RUN;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= DRCD_RUN;
      cnt_ff   <= CNT_RESET;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // ==========================================================================
  // register bus
  wire        wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // write lands on the edge that sees ack high
  wire        wb_wr    = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
  wire        sel_ctrl = (wb_adr_i == REG_CTRL);
  wire        sel_sts  = (wb_adr_i == REG_STATUS);
  wire        sel_pc   = (wb_adr_i == REG_PC);
  wire        ctrl_wr  = wb_wr & sel_ctrl;
  wire        sts_wr   = wb_wr & sel_sts;

  // ==========================================================================
  // control, interrupt and pc state
  logic              int_en_ff;
  logic              ovf_ff;
  logic              irq_flag_latch_ff;
  logic [ADDR_W-1:0] pc_ff;
  wire               int_fall  = int_prev_ff & ~int_sync_n;
  wire               irq_clr   = int_grant_i | (sts_wr & wb_dat_i[STS_IRQ]);
  wire               nxt_irq   = init_active ? 1'b0 :
                                 int_fall ? 1'b1 :
                                 irq_clr ? 1'b0 : irq_flag_latch_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_en_ff         <= 1'b0;
      ovf_ff            <= 1'b0;
      irq_flag_latch_ff <= 1'b0;
      int_prev_ff       <= 1'b1;
      pc_ff             <= ADDR_RESET;
    end else begin
      int_prev_ff       <= int_sync_n;
      irq_flag_latch_ff <= nxt_irq;
      if (init_active) begin
        int_en_ff <= 1'b0;
      end else if (ctrl_wr) begin
        int_en_ff <= wb_dat_i[CTRL_INT_EN];
      end
      if (ctrl_wr) begin
        ovf_ff <= wb_dat_i[CTRL_OVF];
      end
      if (pc_clear) begin
        pc_ff <= ADDR_RESET;
      end else if (core_pc_we_i && !init_active) begin
        pc_ff <= core_pc_i;
      end
    end
  end

  // ==========================================================================
  // bus pins
  logic [DATA_W-1:0] data_ff;
  logic              data_oe_ff;
  drcd_strobes_t     strobes_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_ff    <= '0;
      data_oe_ff <= 1'b0;
      strobes_ff <= '1;
    end else begin
      data_ff    <= core_wr_data_i;
      data_oe_ff <= core_wr_oe_i & ~init_active;
      strobes_ff <= init_active ? drcd_strobes_t'('1) : core_strobes_i;
    end
  end

  // ==========================================================================
  // wishbone read path
  logic [31:0] rdat_ff;
  logic        ack_ff;
  wire  [31:0] ctrl_rd = {30'h0, ovf_ff, int_en_ff};
  wire  [31:0] sts_rd  = {28'h0, ~int_sync_n, state_ff == DRCD_QUAL, init_active, irq_flag_latch_ff};
  wire  [31:0] pc_rd   = {16'h0, pc_ff};
  wire  [31:0] rd_mux  = sel_ctrl ? ctrl_rd : sel_sts ? sts_rd : sel_pc ? pc_rd : 32'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h0;
    end else begin
      ack_ff  <= wb_req;
      rdat_ff <= wb_req ? rd_mux : 32'h0;
    end
  end

  assign wb_ack_o              = ack_ff;
  assign wb_dat_o              = rdat_ff;
  assign data_o                = data_ff;
  assign data_oe_o             = data_oe_ff;
  assign core_rd_data_o        = data_sync;
  assign addr_o                = pc_ff;
  assign strobes_o             = strobes_ff;
  assign system_clock_output_o = sysclk_ff;
  assign sys_ce_o              = sys_ce;
  assign init_active_o         = init_active;
  assign int_pending_o         = int_en_ff & (irq_flag_latch_ff | ~int_sync_n);
  assign ovf_mode_o            = ovf_ff;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_strobes_parked: assert property (init_active |=> strobes_o == '1)
    else $error("strobe active during initialization");
  a_data_float: assert property (init_active |=> !data_oe_o)
    else $error("data bus driven during initialization");
  a_pc_cleared: assert property (pc_clear |=> (pc_ff == ADDR_RESET) && (addr_o == ADDR_RESET))
    else $error("pc not cleared after one full cycle");
  a_int_disabled: assert property (init_active |=> !int_en_ff && !irq_flag_latch_ff)
    else $error("interrupt still enabled in initialization");
  a_ovf_kept: assert property (init_active && !ctrl_wr |=> $stable(ovf_ff))
    else $error("overflow mode changed by initialization");
  a_reset_held: assert property (cnt_sat && init_active ##1 init_active |-> state_ff == DRCD_QUAL)
    else $error("reset state left while input low");
  a_quarter_clock: assert property (sys_ce |=> !sys_ce [*3] ##1 sys_ce)
    else $error("system clock not divide by four");
  a_qualify_five: assert property (state_ff == DRCD_RUN && init_active |-> ##[15:24] state_ff != DRCD_INIT)
    else $error("initialization not qualified in five cycles");
  a_irq_edge: assert property (int_fall && !init_active |=> irq_flag_latch_ff)
    else $error("interrupt edge lost");
  a_init_sync: assert property (##2 1'b1 |-> init_sync_n == $past(init_request_n_i, 2))
    else $error("initialization input not two stage synchronised");

  c_init_qualified: cover property (state_ff == DRCD_INIT ##1 state_ff == DRCD_QUAL);
  c_short_init: cover property (state_ff == DRCD_INIT ##1 state_ff == DRCD_RUN);
  c_irq_granted: cover property (irq_flag_latch_ff && int_grant_i ##1 !irq_flag_latch_ff);
endmodule // dsp_reset_and_clock_divider
